// File: bench/descriptor_walk_attributes_test.sv
// self-checking bench of the descriptor walker against a reference walk
`timescale 1ns/1ps
`include "walk_map.svh"

module descriptor_walk_attributes_test;
	import walk_pkg::*;
	localparam logic [31:0] ROOT = 32'h0000100c; // low nibble must be ignored
	localparam logic [9:0]  RLIM = 10'd5;
	logic        clock_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic        req_valid_i = 1'b0;
	xlat_req_t   req_i = '0;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [11:0] paddr_i = '0;
	logic [31:0] pwdata_i = '0;
	logic        req_ready_o, resp_valid_o, mem_valid_o, mem_ack_i;
	logic        pready_o, pslverr_o;
	xlat_resp_t  resp_o;
	mem_req_t    mem_req_o;
	logic [63:0] mem_rdata_i;
	logic [31:0] prdata_o;
	int          err_total = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	logic [63:0] ref_mem [logic [31:0]];

	descriptor_walk_attributes #(.ENTRIES(4)) dut_u (.clock_i(clock_i),
		.nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_i(req_i),
		.req_ready_o(req_ready_o), .resp_valid_o(resp_valid_o),
		.resp_o(resp_o), .mem_valid_o(mem_valid_o), .mem_req_o(mem_req_o),
		.mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o));
	table_memory mem_u (.clock_i(clock_i), .nrst_i(nrst_i),
		.mem_valid_i(mem_valid_o), .mem_req_i(mem_req_o),
		.mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

	// free-running clock and a hang guard
	always #25 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end

	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic cmp_resp(string n, xlat_resp_t e, xlat_resp_t g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic cmp_bits(string n, logic [63:0] e, logic [63:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask

	// apb master: setup, access, hold until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic er);
		@(posedge clock_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		@(posedge clock_i);
		while (pready_o !== 1'b1) @(posedge clock_i);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	// one translation: hold the request until accepted, then await answer
	task automatic xlat(input logic [31:0] va, input logic wr,
		output xlat_resp_t r);
		@(posedge clock_i);
		req_valid_i <= 1'b1;
		req_i <= '{vaddr: va, write: wr};
		@(posedge clock_i);
		while (req_ready_o !== 1'b1) @(posedge clock_i);
		req_valid_i <= 1'b0;
		@(posedge clock_i);
		while (resp_valid_o !== 1'b1) @(posedge clock_i);
		r = resp_o;
	endtask

	function automatic logic bad(logic [63:0] d, logic [9:0] i);
		return d[7] ? (i < d[17:8]) : (i > d[17:8]);
	endfunction

	// reference walk over the bench's own copy of the tables
	function automatic xlat_resp_t ref_x(logic [31:0] va);
		logic [63:0] d;
		xlat_resp_t  f;
		f = '{paddr: 32'h0, fault: 1'b1};
		if (va[31:22] > RLIM) return f;
		d = ref_mem[{ROOT[31:4], 4'h0} + va[31:22] * 8];
		if (d[1:0] == 2'b00) return f;
		if (bad(d, va[21:12])) return f;
		if (d[1:0] == 2'b01) return '{paddr: {d[63:54], va[21:0]}, fault: 1'b0};
		d = ref_mem[{d[63:36], 4'h0} + va[21:12] * 8];
		if (d[1] == 1'b1) d = ref_mem[{d[63:35], 3'b000}];
		if (d[1:0] != 2'b01) return f;
		return '{paddr: {d[63:44], va[11:0]}, fault: 1'b0};
	endfunction

	task automatic go(input logic [31:0] va, input logic wr);
		xlat_resp_t r;
		xlat(va, wr, r);
		cmp_resp("xlat", ref_x(va), r);
	endtask

	task automatic put(logic [31:0] a, logic [63:0] d);
		mem_u.mem[a] = d;
		ref_mem[a] = d;
	endtask

	task automatic endt(string n);
		$display("test %s done at cycle %0d", n, cyc);
	endtask

	// main sequence
	initial begin
		logic [31:0] rd;
		logic        er;
		logic [11:0] o;
		int          n;
		xlat_resp_t  r;
		void'($urandom(32'h281fc4ab));
		// tables on 16-byte boundaries, spare bits filled with junk
		put(32'h1008, 64'h00002000_00100302);
		put(32'h2010, 64'habcde000_00c00001);
		put(32'h1010, 64'h40000000_00000509);
		put(32'h1018, 64'h00003000_0003ff02);
		put(32'h3000, 64'h00004008_00000002);
		put(32'h4008, 64'h55555000_00000001);
		put(32'h1020, 64'hdeadbeef_fffffffc);
		put(32'h1028, 64'h00005000_0003ff02);
		put(32'h5000, 64'h77777000_00000069);
		repeat (6) @(posedge clock_i);
		nrst_i <= 1'b1;
		apb(1'b0, `OFF_ROOT_LIMIT, 32'h0, rd, er);
		cmp_bits("root_limit_reset", 64'h3ff, {32'h0, rd});
		apb(1'b1, `OFF_ROOT, ROOT, rd, er);
		apb(1'b1, `OFF_ROOT_LIMIT, {22'h0, RLIM}, rd, er);
		xlat(32'h00402abc, 1'b1, r);
		cmp_resp("bypass", '{paddr: 32'h00402abc, fault: 1'b0}, r);
		apb(1'b1, `OFF_CTRL, 32'h00000101, rd, er);
		apb(1'b0, 12'h020, 32'h0, rd, er);
		cmp_bits("unmapped_err", 64'h1, {63'h0, er});
		endt("registers");
		o = 12'($urandom);
		go({10'd1, 10'd2, o}, 1'b0);
		cmp_bits("used_set", 64'habcde000_00c00009, mem_u.mem[32'h2010]);
		cmp_bits("pointer_kept", ref_mem[32'h1008], mem_u.mem[32'h1008]);
		go({10'd1, 10'd4, o}, 1'b0);
		go({10'd6, 10'd0, o}, 1'b0);
		endt("two_level");
		n = mem_u.xfers;
		go({10'd2, 10'd5, o}, 1'b0);
		go({10'd2, 10'd3, ~o}, 1'b0);
		go({10'd2, 10'd5, ~o}, 1'b0);
		go({10'd2, 10'd3, o}, 1'b0);
		cmp_bits("early_fetches", 64'd2, 64'(mem_u.xfers - n));
		go({10'd2, 10'd6, o}, 1'b0);
		endt("early_page");
		go({10'd3, 10'd0, o}, 1'b1);
		cmp_bits("primary", 64'h55555000_00000019, mem_u.mem[32'h4008]);
		cmp_bits("indirect", 64'h00004008_00000002, mem_u.mem[32'h3000]);
		endt("indirect");
		go({10'd4, 10'd0, o}, 1'b0);
		cmp_bits("invalid_kept", 64'hdeadbeef_fffffffc, mem_u.mem[32'h1020]);
		apb(1'b0, `OFF_FAULT_ADDR, 32'h0, rd, er);
		cmp_bits("fault_addr", {32'h0, 10'd4, 10'd0, o}, {32'h0, rd});
		apb(1'b0, `OFF_STATUS, 32'h0, rd, er);
		cmp_bits("status", 64'h0007_0002, {32'h0, rd});
		apb(1'b1, `OFF_STATUS, 32'h2, rd, er);
		apb(1'b0, `OFF_STATUS, 32'h0, rd, er);
		cmp_bits("status_clear", 64'h0007_0000, {32'h0, rd});
		endt("invalid");
		go({10'd5, 10'd0, o}, 1'b0);
		apb(1'b1, `OFF_CTRL, 32'h00000201, rd, er);
		n = mem_u.xfers;
		go({10'd5, 10'd0, ~o}, 1'b0);
		cmp_bits("global_fetches", 64'd0, 64'(mem_u.xfers - n));
		endt("global");
		apb(1'b1, `OFF_CTRL, 32'h00000103, rd, er);
		apb(1'b0, `OFF_CTRL, 32'h0, rd, er);
		cmp_bits("ctrl_read", 64'h101, {32'h0, rd});
		n = mem_u.xfers;
		go({10'd5, 10'd0, o}, 1'b0);
		go({10'd2, 10'd5, o}, 1'b0);
		cmp_bits("flush_fetches", 64'd1, 64'(mem_u.xfers - n));
		endt("lock_flush");
		summarize();
	end
endmodule

// File: bench/table_memory.sv
// behavioural memory holding the translation tables
`timescale 1ns/1ps

module table_memory (
	input  wire logic          clock_i,
	input  wire logic          nrst_i,
	input  wire logic          mem_valid_i,
	input  walk_pkg::mem_req_t mem_req_i,
	output logic               mem_ack_o,
	output logic [63:0]        mem_rdata_o
);
	import walk_pkg::*;
	logic [63:0] mem [logic [31:0]];
	int          xfers;
	int          wait_q;

	// one 64-bit beat per request, after a random stall of zero to three cycles
	always @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mem_ack_o <= 1'b0;
			mem_rdata_o <= '0;
			wait_q <= 0;
			xfers <= 0;
		end else if (mem_ack_o) begin
			mem_ack_o <= 1'b0;
			mem_rdata_o <= ~mem_rdata_o; // released data must not linger
		end else if (mem_valid_i && wait_q > 0) begin
			wait_q <= wait_q - 1;
		end else if (mem_valid_i) begin
			mem_ack_o <= 1'b1;
			xfers <= xfers + 1;
			wait_q <= $urandom_range(3, 0);
			if (mem_req_i.we) begin
				mem[mem_req_i.addr] = mem_req_i.wdata;
			end else begin
				mem_rdata_o <= mem[mem_req_i.addr];
			end
		end
	end
endmodule

// File: hdl/descriptor_decode.sv
// field extraction for one fetched descriptor
`timescale 1ns/1ps
`include "walk_map.svh"

module descriptor_decode (
	input  wire logic [63:0]  raw_i,
	output walk_pkg::desc_t   desc_o
);
	import walk_pkg::*;

	// only defined fields are lifted; an invalid one shows its kind alone
	always_comb begin
		desc_o = '0;
		desc_o.kind = desc_kind_t'(raw_i[`DESC_TYPE_HI:`DESC_TYPE_LO]);
		if (desc_o.kind != KIND_INVALID) begin
			desc_o.wp = raw_i[`DESC_WP_BIT];
			desc_o.used = raw_i[`DESC_USED_BIT];
			desc_o.modified = raw_i[`DESC_MOD_BIT];
			desc_o.lock = raw_i[`DESC_LOCK_BIT];
			desc_o.global_share_flag = raw_i[`DESC_GLOBAL_BIT];
			desc_o.limit_lower = raw_i[`DESC_LOWER_BIT];
			desc_o.limit = raw_i[`DESC_LIMIT_HI:`DESC_LIMIT_LO];
			desc_o.addr = raw_i[`DESC_ADDR_HI:`DESC_ADDR_LO];
		end
	end

endmodule

// File: hdl/descriptor_walk_attributes.sv
// descriptor walker: table search, descriptor flags, apb registers
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "walk_map.svh"

// Notes on behaviour
// - page descriptor above lowest level ends walk
// - early page descriptor's own limit restricts the early block
// - one cache entry per accessed page
// - block relocated by early descriptor base address
// - pointer at page level fetches primary descriptor
// - used flag set only in primary descriptor
// - write sets only the primary modified flag
// - global entries shared by all tasks, once
// - undefined descriptor bits never interpreted nor changed
// - invalid descriptor: only two type bits examined
// - tables start on sixteen byte boundaries
// - fully associative cache of 64 entries
// - locked entries stay resident, never replaced
module descriptor_walk_attributes #(
	parameter int ENTRIES = 64
) (
	input  wire logic             clock_i,
	input  wire logic             nrst_i,
	input  wire logic             req_valid_i,
	input  walk_pkg::xlat_req_t   req_i,
	output logic                  req_ready_o,
	output logic                  resp_valid_o,
	output walk_pkg::xlat_resp_t  resp_o,
	output logic                  mem_valid_o,
	output walk_pkg::mem_req_t    mem_req_o,
	input  wire logic             mem_ack_i,
	input  wire logic [63:0]      mem_rdata_i,
	input  wire logic             psel_i,
	input  wire logic             penable_i,
	input  wire logic             pwrite_i,
	input  wire logic [11:0]      paddr_i,
	input  wire logic [31:0]      pwdata_i,
	output logic [31:0]           prdata_o,
	output logic                  pready_o,
	output logic                  pslverr_o
);
	import walk_pkg::*;

	// every flip-flop of the walker and its registers
	typedef struct packed {
		walk_state_t st;
		logic        level;
		logic [31:0] vaddr;
		logic        write;
		logic [31:0] maddr;
		logic [63:0] draw;
		logic [19:0] pfn;
		logic        wp;
		logic        lock;
		logic        glob;
		logic        mod;
		logic        resp_valid;
		xlat_resp_t  resp;
		logic        enable;
		logic        flush;
		logic [7:0]  task_id;
		logic [27:0] root_base;
		logic [9:0]  root_limit;
		logic        root_lower;
		logic        last_fault;
		logic [31:0] fault_addr;
		logic [15:0] walk_count;
		logic [31:0] prdata;
	} core_state_t;

	// the only descriptor bits the walker ever rewrites
	localparam logic [63:0] FLAG_MASK = (64'h1 << `DESC_USED_BIT)
		| (64'h1 << `DESC_MOD_BIT);

	core_state_t   q;
	core_state_t   n;
	desc_t         dec;
	logic          look_hit;
	cache_entry_t  look_entry;
	cache_entry_t  fill_entry;
	logic [9:0]    idx0_req;
	logic [9:0]    idx1;
	logic          lim_bad;
	logic          page_now;
	logic          fault_now;
	logic          need_upd;
	logic          apb_wr;
	logic          mapped;
	logic [31:0]   rd_mux;

	// limit test: upper form caps the index, lower form floors it
	function automatic logic over_limit(input logic [9:0] idx,
			input logic [9:0] lim, input logic lower);
		return lower ? (idx < lim) : (idx > lim);
	endfunction

	// entry address inside a 16-byte aligned table of 8-byte descriptors
	function automatic logic [31:0] entry_addr(input logic [27:0] base,
			input logic [9:0] idx);
		return {base, 4'h0} + {19'h0, idx, 3'h0};
	endfunction

	descriptor_decode u_decode (
		.raw_i  (mem_rdata_i),
		.desc_o (dec)
	);

	translation_cache #(
		.ENTRIES (ENTRIES)
	) u_cache (
		.clock_i      (clock_i),
		.nrst_i       (nrst_i),
		.look_vpn_i   (req_i.vaddr[`L0_IDX_HI:`L1_IDX_LO]),
		.look_task_i  (q.task_id),
		.look_hit_o   (look_hit),
		.look_entry_o (look_entry),
		.fill_i       (q.st == S_FILL),
		.fill_entry_i (fill_entry),
		.flush_i      (q.flush)
	);

	// index fields and the limit of the descriptor just fetched
	assign idx0_req = req_i.vaddr[`L0_IDX_HI:`L0_IDX_LO];
	assign idx1 = q.vaddr[`L1_IDX_HI:`L1_IDX_LO];
	assign lim_bad = over_limit(idx1, dec.limit, dec.limit_lower);

	// entry loaded for the accessed page only
	always_comb begin
		fill_entry = '0;
		fill_entry.valid = 1'b1;
		fill_entry.global_share_flag = q.glob;
		fill_entry.lock = q.lock;
		fill_entry.wp = q.wp;
		fill_entry.modified = q.mod;
		fill_entry.task_id = q.task_id;
		fill_entry.vpn = q.vaddr[`L0_IDX_HI:`L1_IDX_LO];
		fill_entry.pfn = q.pfn;
	end

	// apb decode: zero wait states, error on unmapped words
	assign apb_wr = psel_i && penable_i && pwrite_i;
	assign mapped = paddr_i == `OFF_CTRL || paddr_i == `OFF_ROOT
		|| paddr_i == `OFF_ROOT_LIMIT || paddr_i == `OFF_STATUS
		|| paddr_i == `OFF_FAULT_ADDR;

	// read data mux, sampled in the setup cycle
	always_comb begin
		rd_mux = '0;
		case (paddr_i)
		`OFF_CTRL: begin
			rd_mux[`CTRL_ENABLE_BIT] = q.enable;
			rd_mux[`CTRL_TASK_HI:`CTRL_TASK_LO] = q.task_id;
		end
		`OFF_ROOT: begin
			rd_mux[31:`ROOT_BASE_LO] = q.root_base;
		end
		`OFF_ROOT_LIMIT: begin
			rd_mux[`RLIM_LIMIT_HI:0] = q.root_limit;
			rd_mux[`RLIM_LOWER_BIT] = q.root_lower;
		end
		`OFF_STATUS: begin
			rd_mux[`STAT_BUSY_BIT] = q.st != S_IDLE;
			rd_mux[`STAT_FAULT_BIT] = q.last_fault;
			rd_mux[`STAT_COUNT_HI:`STAT_COUNT_LO] = q.walk_count;
		end
		`OFF_FAULT_ADDR: begin
			rd_mux = q.fault_addr;
		end
		default: begin
			rd_mux = '0;
		end
		endcase
	end

	// next state: register writes, then the table search
	always_comb begin
		n = q;
		n.resp_valid = 1'b0;
		n.flush = 1'b0;
		page_now = 1'b0;
		fault_now = 1'b0;
		need_upd = 1'b0;
		if (psel_i && !penable_i) begin
			n.prdata = rd_mux;
		end
		if (apb_wr) begin
			case (paddr_i)
			`OFF_CTRL: begin
				n.enable = pwdata_i[`CTRL_ENABLE_BIT];
				n.flush = pwdata_i[`CTRL_FLUSH_BIT];
				n.task_id = pwdata_i[`CTRL_TASK_HI:`CTRL_TASK_LO];
			end
			`OFF_ROOT: begin
				n.root_base = pwdata_i[31:`ROOT_BASE_LO];
			end
			`OFF_ROOT_LIMIT: begin
				n.root_limit = pwdata_i[`RLIM_LIMIT_HI:0];
				n.root_lower = pwdata_i[`RLIM_LOWER_BIT];
			end
			`OFF_STATUS: begin
				if (pwdata_i[`STAT_FAULT_BIT]) begin
					n.last_fault = 1'b0;
				end
			end
			default: begin
				n.prdata = q.prdata;
			end
			endcase
		end
		unique case (q.st)
		S_IDLE: begin
			if (req_valid_i) begin
				n.vaddr = req_i.vaddr;
				n.write = req_i.write;
				if (!q.enable) begin
					n.resp_valid = 1'b1;
					n.resp.paddr = req_i.vaddr;
					n.resp.fault = 1'b0;
				end else if (look_hit && req_i.write && look_entry.wp) begin
					fault_now = 1'b1;
				end else if (look_hit
						&& !(req_i.write && !look_entry.modified)) begin
					n.resp_valid = 1'b1;
					n.resp.paddr = {look_entry.pfn,
						req_i.vaddr[`PAGE_OFF_HI:0]};
					n.resp.fault = 1'b0;
				end else if (over_limit(idx0_req, q.root_limit,
						q.root_lower)) begin
					fault_now = 1'b1;
				end else begin
					n.level = 1'b0;
					n.maddr = entry_addr(q.root_base, idx0_req);
					n.st = S_FETCH;
					n.walk_count = q.walk_count + 16'h1;
				end
			end
		end
		S_FETCH: begin
			if (mem_ack_i) begin
				unique case (dec.kind)
				KIND_INVALID: begin
					fault_now = 1'b1;
				end
				KIND_PAGE: begin
					if (!q.level && lim_bad) begin
						fault_now = 1'b1;
					end else begin
						page_now = 1'b1;
					end
				end
				KIND_PTR_SHORT, KIND_PTR_LONG: begin
					if (q.level) begin
						n.st = S_INDIRECT;
						n.maddr = {dec.addr[31:3], 3'h0};
					end else if (lim_bad) begin
						fault_now = 1'b1;
					end else begin
						n.level = 1'b1;
						n.maddr = entry_addr(dec.addr[31:4], idx1);
					end
				end
				endcase
			end
		end
		S_INDIRECT: begin
			if (mem_ack_i) begin
				if (dec.kind == KIND_PAGE) begin
					page_now = 1'b1;
				end else begin
					fault_now = 1'b1;
				end
			end
		end
		S_UPDATE: begin
			if (mem_ack_i) begin
				n.st = S_FILL;
			end
		end
		S_FILL: begin
			n.st = S_IDLE;
			n.resp_valid = 1'b1;
			n.resp.paddr = {q.pfn, q.vaddr[`PAGE_OFF_HI:0]};
			n.resp.fault = 1'b0;
		end
		default: begin
			n.st = S_IDLE;
		end
		endcase
		// page found: keep every other bit, set used, and modified on a write only
		if (page_now) begin
			n.draw = mem_rdata_i;
			n.draw[`DESC_USED_BIT] = 1'b1;
			if (q.write) begin
				n.draw[`DESC_MOD_BIT] = 1'b1;
			end
			n.pfn = q.level ? dec.addr[31:12]
				: {dec.addr[31:22], q.vaddr[`L1_IDX_HI:`L1_IDX_LO]};
			n.wp = dec.wp;
			n.lock = dec.lock;
			n.glob = dec.global_share_flag;
			n.mod = dec.modified | q.write;
			if (q.write && dec.wp) begin
				fault_now = 1'b1;
			end else if (!dec.used || (q.write && !dec.modified)) begin
				need_upd = 1'b1;
				n.st = S_UPDATE;
			end else begin
				n.st = S_FILL;
			end
		end
		// a fault ends the search; the flag set outranks a clear
		if (fault_now) begin
			n.st = S_IDLE;
			n.resp_valid = 1'b1;
			n.resp.paddr = '0;
			n.resp.fault = 1'b1;
			n.last_fault = 1'b1;
			n.fault_addr = n.vaddr;
		end
	end

	// state register
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q <= '0;
			q.st <= S_IDLE;
			q.root_limit <= `RST_ROOT_LIMIT;
		end else begin
			q <= n;
		end
	end

	// outputs; the write-back always targets the page descriptor address
	assign req_ready_o = q.st == S_IDLE;
	assign resp_valid_o = q.resp_valid;
	assign resp_o = q.resp;
	assign mem_valid_o = q.st == S_FETCH || q.st == S_INDIRECT
		|| q.st == S_UPDATE;
	assign mem_req_o.we = q.st == S_UPDATE;
	assign mem_req_o.addr = q.maddr;
	assign mem_req_o.wdata = q.draw;
	assign prdata_o = q.prdata;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !mapped;

	// helper terms for the checks below
	logic        early_take;
	logic [19:0] block_pfn;
	logic [31:0] maddr_q;
	assign early_take = q.st == S_FETCH && !q.level && mem_ack_i
		&& dec.kind == KIND_PAGE && !lim_bad && !(q.write && dec.wp);
	assign block_pfn = {dec.addr[31:22], q.vaddr[`L1_IDX_HI:`L1_IDX_LO]};
	assign maddr_q = q.maddr;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);

	a_early_block : assert property (
		early_take |=> q.st == S_UPDATE || q.st == S_FILL)
		else $error("early page did not end the search");

	a_block_base : assert property (
		early_take |=> q.pfn == $past(block_pfn))
		else $error("early block not relocated by its base");

	a_limit_fault : assert property (
		q.st == S_FETCH && !q.level && mem_ack_i
		&& dec.kind == KIND_PAGE && lim_bad
		|=> resp_valid_o && resp_o.fault)
		else $error("block beyond limit was not faulted");

	a_indirect_go : assert property (
		q.st == S_FETCH && q.level && mem_ack_i && dec.kind[1]
		|=> q.st == S_INDIRECT && mem_valid_o && !mem_req_o.we)
		else $error("pointer at page level not followed");

	a_primary_write : assert property (
		q.st == S_INDIRECT && need_upd
		|=> mem_req_o.we && mem_req_o.addr == $past(maddr_q))
		else $error("flag write missed the primary descriptor");

	a_one_modified : assert property (
		need_upd && q.write
		|=> mem_req_o.we && mem_req_o.wdata[`DESC_MOD_BIT])
		else $error("write did not mark the primary modified");

	a_single_update : assert property (
		mem_valid_o && mem_req_o.we && mem_ack_i |=> !mem_req_o.we)
		else $error("descriptor written back more than once");

	a_spare_kept : assert property (
		need_upd
		|=> ((mem_req_o.wdata ^ $past(mem_rdata_i)) & ~FLAG_MASK) == '0)
		else $error("undefined descriptor bits were altered");

	a_invalid_fault : assert property (
		(q.st == S_FETCH || q.st == S_INDIRECT) && mem_ack_i
		&& dec.kind == KIND_INVALID |=> resp_valid_o && resp_o.fault)
		else $error("invalid descriptor not faulted");

	a_table_align : assert property (
		q.st == S_FETCH |-> q.maddr[2:0] == 3'h0)
		else $error("descriptor fetch off its table grid");

	a_pointer_walk : assert property (
		q.st == S_FETCH && !q.level && mem_ack_i && dec.kind[1]
		&& !lim_bad |=> q.st == S_FETCH && q.level)
		else $error("pointer did not descend a level");

	c_early_page : cover property (early_take ##[1:4] resp_valid_o);
	c_indirect : cover property (q.st == S_INDIRECT && mem_ack_i);
	c_write_update : cover property (mem_req_o.we && q.write);
	c_cache_hit : cover property (req_valid_i && req_ready_o && look_hit);

endmodule

// File: hdl/translation_cache.sv
// fully associative translation cache with locked entries
`timescale 1ns/1ps

module translation_cache #(
	parameter int ENTRIES = 64
) (
	input  wire logic               clock_i,
	input  wire logic               nrst_i,
	input  wire logic [19:0]        look_vpn_i,
	input  wire logic [7:0]         look_task_i,
	output logic                    look_hit_o,
	output walk_pkg::cache_entry_t  look_entry_o,
	input  wire logic               fill_i,
	input  walk_pkg::cache_entry_t  fill_entry_i,
	input  wire logic               flush_i
);
	import walk_pkg::*;

	localparam int IW = $clog2(ENTRIES);

	typedef struct packed {
		cache_entry_t [ENTRIES-1:0] ent;
		logic [IW-1:0]              ptr;
	} cache_state_t;

	cache_state_t        q;
	cache_state_t        d;
	logic [ENTRIES-1:0]  look_match;
	logic [ENTRIES-1:0]  fill_match;
	logic                fill_hit;
	logic [IW-1:0]       fill_idx;
	logic                vic_found;
	logic [IW-1:0]       vic_idx;
	logic [IW-1:0]       probe;

	// the rotating victim pointer needs a power of two
	if (ENTRIES < 2 || ENTRIES > 256 || (ENTRIES & (ENTRIES - 1)) != 0)
	begin : g_bad_size
		$error("ENTRIES must be a power of two from 2 to 256");
	end

	// per entry compare; global entries answer every task
	for (genvar g = 0; g < ENTRIES; g++) begin : g_entry
		assign look_match[g] = q.ent[g].valid
			&& q.ent[g].vpn == look_vpn_i
			&& (q.ent[g].global_share_flag
			|| q.ent[g].task_id == look_task_i);
		assign fill_match[g] = q.ent[g].valid
			&& q.ent[g].vpn == fill_entry_i.vpn
			&& (q.ent[g].global_share_flag
			|| fill_entry_i.global_share_flag
			|| q.ent[g].task_id == fill_entry_i.task_id);
	end

	// lookup result
	always_comb begin
		look_hit_o = 1'b0;
		look_entry_o = '0;
		for (int i = 0; i < ENTRIES; i++) begin
			if (look_match[i]) begin
				look_hit_o = 1'b1;
				look_entry_o = q.ent[i];
			end
		end
	end

	// fill over a same-page entry, else free slot, else unlocked victim
	always_comb begin
		d = q;
		fill_hit = 1'b0;
		fill_idx = '0;
		vic_found = 1'b0;
		vic_idx = q.ptr;
		probe = '0;
		for (int i = 0; i < ENTRIES; i++) begin
			if (fill_match[i]) begin
				fill_hit = 1'b1;
				fill_idx = IW'(i);
			end
		end
		for (int k = ENTRIES - 1; k >= 0; k--) begin
			probe = q.ptr + IW'(k);
			if (!q.ent[probe].lock) begin
				vic_found = 1'b1;
				vic_idx = probe;
			end
		end
		for (int k = ENTRIES - 1; k >= 0; k--) begin
			probe = q.ptr + IW'(k);
			if (!q.ent[probe].valid) begin
				vic_found = 1'b1;
				vic_idx = probe;
			end
		end
		if (flush_i) begin
			for (int i = 0; i < ENTRIES; i++) begin
				if (!q.ent[i].lock) begin
					d.ent[i].valid = 1'b0;
				end
			end
		end
		if (fill_i) begin
			// a global fill retires every unlocked copy of its page
			for (int i = 0; i < ENTRIES; i++) begin
				if (fill_match[i] && !q.ent[i].lock
						&& fill_entry_i.global_share_flag) begin
					d.ent[i].valid = 1'b0;
				end
			end
			if (fill_hit) begin
				d.ent[fill_idx] = fill_entry_i;
			end else if (vic_found) begin
				d.ent[vic_idx] = fill_entry_i;
				d.ptr = vic_idx + IW'(1);
			end
		end
	end

	// state register
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	a_single_entry : assert property (
		@(posedge clock_i) disable iff (!nrst_i) $onehot0(look_match))
		else $error("two cache entries answer one page");

	a_lock_resident : assert property (
		@(posedge clock_i) disable iff (!nrst_i)
		q.ent[0].valid && q.ent[0].lock |=> q.ent[0].valid)
		else $error("locked cache entry was dropped");

endmodule

// File: hdl/walk_map.svh
// offsets, field positions and reset values of the descriptor walker
`ifndef WALK_MAP_SVH
`define WALK_MAP_SVH

// descriptor word: low half holds kind and flags, high half the address
`define DESC_TYPE_LO    0
`define DESC_TYPE_HI    1
`define DESC_WP_BIT     2
`define DESC_USED_BIT   3
`define DESC_MOD_BIT    4
`define DESC_LOCK_BIT   5
`define DESC_GLOBAL_BIT 6
`define DESC_LOWER_BIT  7
`define DESC_LIMIT_LO   8
`define DESC_LIMIT_HI   17
`define DESC_ADDR_LO    32
`define DESC_ADDR_HI    63

// virtual address split: upper index, page index, page offset
`define L0_IDX_HI       31
`define L0_IDX_LO       22
`define L1_IDX_HI       21
`define L1_IDX_LO       12
`define PAGE_OFF_HI     11

// register offsets on the apb slave
`define OFF_CTRL        12'h000
`define OFF_ROOT        12'h004
`define OFF_ROOT_LIMIT  12'h008
`define OFF_STATUS      12'h00c
`define OFF_FAULT_ADDR  12'h010

// register fields
`define CTRL_ENABLE_BIT 0
`define CTRL_FLUSH_BIT  1
`define CTRL_TASK_LO    8
`define CTRL_TASK_HI    15
`define ROOT_BASE_LO    4
`define RLIM_LIMIT_HI   9
`define RLIM_LOWER_BIT  16
`define STAT_BUSY_BIT   0
`define STAT_FAULT_BIT  1
`define STAT_COUNT_LO   16
`define STAT_COUNT_HI   31

// reset values
`define RST_ROOT_LIMIT  10'h3ff

`endif

// File: hdl/walk_pkg.sv
// shared types of the descriptor walker
package walk_pkg;

	typedef enum logic [1:0] {
		KIND_INVALID   = 2'b00,
		KIND_PAGE      = 2'b01,
		KIND_PTR_SHORT = 2'b10,
		KIND_PTR_LONG  = 2'b11
	} desc_kind_t;

	typedef enum logic [2:0] {
		S_IDLE     = 3'b000,
		S_FETCH    = 3'b001,
		S_INDIRECT = 3'b010,
		S_UPDATE   = 3'b011,
		S_FILL     = 3'b100
	} walk_state_t;

	typedef struct packed {
		desc_kind_t  kind;
		logic        wp;
		logic        used;
		logic        modified;
		logic        lock;
		logic        global_share_flag;
		logic        limit_lower;
		logic [9:0]  limit;
		logic [31:0] addr;
	} desc_t;

	typedef struct packed {
		logic        valid;
		logic        global_share_flag;
		logic        lock;
		logic        wp;
		logic        modified;
		logic [7:0]  task_id;
		logic [19:0] vpn;
		logic [19:0] pfn;
	} cache_entry_t;

	typedef struct packed {
		logic [31:0] vaddr;
		logic        write;
	} xlat_req_t;

	typedef struct packed {
		logic [31:0] paddr;
		logic        fault;
	} xlat_resp_t;

	typedef struct packed {
		logic        we;
		logic [31:0] addr;
		logic [63:0] wdata;
	} mem_req_t;

endpackage
